/* File: rtl/epo_defines.vh */
// Constants for the energy pulse output stage: timing, register map, fields, codes.
// Assumes inclusion by bare name from the rtl/ modules; definitions only.
`ifndef EPO_DEFINES_VH
`define EPO_DEFINES_VH
`define EPO_CLK_PERIOD_NS 5
`define EPO_TICK_TIME_NS 1000000
`define EPO_MS_PER_S 32'h0000_03e8
`define EPO_ADDR_CTRL 4'h0
`define EPO_ADDR_PORTS 4'h1
`define EPO_ADDR_SW_DUR 4'h2
`define EPO_ADDR_PUL_DUR 4'h3
`define EPO_ADDR_CAL_DUR 4'h4
`define EPO_ADDR_KT_LO 4'h5
`define EPO_ADDR_KT_HI 4'h6
`define EPO_ADDR_STATUS 4'h7
`define EPO_ADDR_LOG_CNT 4'h8
`define EPO_CTRL_LOG_BIT 0
`define EPO_CTRL_PUL_KYZ_BIT 1
`define EPO_CTRL_CAL_KYZ_BIT 2
`define EPO_CTRL_MODE_LSB 3
`define EPO_CTRL_MODE_MSB 4
`define EPO_PORTS_SW_LSB 0
`define EPO_PORTS_PUL_LSB 4
`define EPO_PORTS_CAL_LSB 8
`define EPO_STATUS_FITTED_BIT 15
`define EPO_MODE_FWD 2'h0
`define EPO_MODE_REV 2'h1
`define EPO_MODE_ABS 2'h2
`define EPO_MODE_NET 2'h3
`define EPO_PORT_NONE 4'h0
`define EPO_NUM_CHAN 15
`define EPO_RST_CTRL 5'h00
`define EPO_RST_PORTS 12'h000
`define EPO_RST_SW_DUR 32'h0000_0000
`define EPO_RST_PUL_DUR 32'h0000_0014
`define EPO_RST_CAL_DUR 32'h0000_000a
`define EPO_RST_KT 40'h00_0000_0064
`define EPO_SW_DUR_MAX 32'h001e_8480
`define EPO_PUL_DUR_MIN 32'h0000_0014
`define EPO_PUL_DUR_MAX 32'h7735_9400
`define EPO_CAL_DUR_MIN 32'h0000_000a
`define EPO_CAL_DUR_MAX 32'h0000_03e8
`define EPO_KT_MIN 40'h00_0000_0001
`define EPO_KT_MAX 40'h17_4876_e800
`endif

/* File: rtl/epo_pulse_gen.v */
// Output shaper for one controlling function: level, timed pulse or transition.
// Assumes a one-cycle millisecond tick and one-cycle trigger strobes on core_clk.
`timescale 1ns/100ps
module epo_pulse_gen (
	// Clock and reset
	input wire core_clk,
	input wire rst_n,
	// Timing and mode
	input wire tick_ms,
	input wire level_mode,
	input wire level_in,
	input wire kyz,
	input wire [31:0] dur_ms,
	// Event and output
	input wire trig,
	output reg pulse_out
);
	reg [31:0] remain;

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pulse_out <= 1'b0;
			remain <= 32'h0000_0000;
		end else if (level_mode) begin
			pulse_out <= level_in;
			remain <= 32'h0000_0000;
		end else if (trig) begin
			if (kyz) begin
				pulse_out <= ~pulse_out;
			end else begin
				pulse_out <= 1'b1;
				remain <= dur_ms;
			end
		end else if (!kyz && pulse_out) begin
			// Pulse ends when the programmed count of ticks has passed
			if (remain == 32'h0000_0000) begin
				pulse_out <= 1'b0;
			end else if (tick_ms) begin
				remain <= remain - 32'h0000_0001;
				if (remain == 32'h0000_0001) begin
					pulse_out <= 1'b0;
				end
			end
		end
	end
endmodule

/* File: rtl/epo_energy_integ.v */
// Energy integrator: accumulates power samples per mode, emits one event per quantum.
// Assumes power samples arrive as signed strobes on core_clk; quantum is never zero.
`timescale 1ns/100ps
`include "epo_defines.vh"
module epo_energy_integ (
	// Clock and reset
	input wire core_clk,
	input wire rst_n,
	// Setup
	input wire [1:0] int_mode,
	input wire [39:0] energy_per_pulse_constant,
	// Power samples
	input wire [31:0] power_sample,
	input wire power_valid,
	// Energy event
	output reg energy_evt
);
	reg signed [47:0] acc;
	reg signed [47:0] contrib;
	reg signed [47:0] acc_sum;
	wire signed [47:0] p_ext = {{16{power_sample[31]}}, power_sample};
	wire signed [47:0] quantum = {8'h00, energy_per_pulse_constant};
	// Debt floor keeps a long reverse flow in net mode from wrapping to a large credit
	wire signed [47:0] acc_floor = 48'shc000_0000_0000;

	always @* begin
		case (int_mode)
			`EPO_MODE_FWD: contrib = p_ext[47] ? 48'sh0 : p_ext;
			`EPO_MODE_REV: contrib = p_ext[47] ? -p_ext : 48'sh0;
			`EPO_MODE_ABS: contrib = p_ext[47] ? -p_ext : p_ext;
			default: contrib = p_ext;
		endcase
		acc_sum = acc + contrib;
	end

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			acc <= 48'sh0;
			energy_evt <= 1'b0;
		end else begin
			energy_evt <= 1'b0;
			if (power_valid) begin
				if (acc_sum >= quantum) begin
					acc <= acc_sum - quantum;
					energy_evt <= 1'b1;
				end else if (acc_sum < acc_floor) begin
					acc <= acc_floor;
				end else begin
					acc <= acc_sum;
				end
			end
		end
	end
endmodule

/* File: rtl/epo_outputs.v */
// Energy pulse output stage: switch, pulser and calibration pulser routed to channels.
// Assumes control strobes and power samples come from logic on core_clk; the option
// strap is an asynchronous pin.
// Overview of operation
// - Four relay outputs and one solid-state output, live only with option fitted.
// - Every channel can carry a steady level or a timed pulse.
// - Each function drives one channel chosen by its port code, or none.
// - Port codes: not-used, two indicator LEDs, onboard relays, expander channels.
// - Switch function shows its Boolean input as a level or as pulses.
// - Switch duration 0 to 2000000 s; zero means output follows input.
// - Output polarity is fixed non-inverted: asserted means energised.
// - Switch function logs each output change when logging is enabled.
// - Pulser turns each incoming event into a pulse or a transition.
// - Pulser duration is programmable from 0.020 to 2000000 s.
// - Pulser and calibration pulser select full pulse or transition style.
// - Calibration pulser emits one pulse per accumulated energy quantum.
// - Calibration pulse duration is programmable from 0.010 to 1.000 s.
// - Calibration pulser offers forward, reverse, absolute and net modes.
`timescale 1ns/100ps
`include "epo_defines.vh"
module epo_outputs #(
	parameter TICK_CYCLES = `EPO_TICK_TIME_NS / `EPO_CLK_PERIOD_NS
) (
	// Clock and reset
	input wire core_clk,
	input wire rst_n,
	// Register port
	input wire [3:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	// Function inputs
	input wire switch_in,
	input wire pulser_evt,
	input wire [31:0] power_sample,
	input wire power_valid,
	// Option strap
	input wire option_fitted,
	// Channel outputs
	output wire active_energy_indicator,
	output wire reactive_energy_indicator,
	output wire [3:0] relay_out,
	output wire solid_state_out,
	output wire [7:0] expander_out,
	// Event log strobe
	output reg log_event
);
	// Setup registers
	reg [4:0] ctrl;
	reg [11:0] ports;
	reg [31:0] sw_dur_s;
	reg [31:0] pul_dur_ms;
	reg [31:0] cal_dur_ms;
	reg [39:0] kt;
	reg [31:0] log_count;

	// Channel state
	reg [`EPO_NUM_CHAN-1:0] chan_q;
	wire [`EPO_NUM_CHAN-1:0] next_chan;

	// Strap synchroniser
	reg fit_meta;
	reg fit_sync;

	// Millisecond divider
	reg [31:0] div_cnt;
	reg tick_ms;

	// Switch input history
	reg sw_prev;
	reg sw_out_prev;

	// Function outputs
	wire sw_out;
	wire pul_out;
	wire cal_out;
	wire cal_evt;

	wire log_en = ctrl[`EPO_CTRL_LOG_BIT];
	wire pul_kyz = ctrl[`EPO_CTRL_PUL_KYZ_BIT];
	wire cal_kyz = ctrl[`EPO_CTRL_CAL_KYZ_BIT];
	wire [1:0] cal_mode = ctrl[`EPO_CTRL_MODE_MSB:`EPO_CTRL_MODE_LSB];
	wire [3:0] sw_port = ports[`EPO_PORTS_SW_LSB+3:`EPO_PORTS_SW_LSB];
	wire [3:0] pul_port = ports[`EPO_PORTS_PUL_LSB+3:`EPO_PORTS_PUL_LSB];
	wire [3:0] cal_port = ports[`EPO_PORTS_CAL_LSB+3:`EPO_PORTS_CAL_LSB];

	// Seconds scaled to milliseconds; the maximum stays below 2^31
	wire [63:0] sw_dur_prod = sw_dur_s * `EPO_MS_PER_S;
	wire [31:0] sw_dur_ms = sw_dur_prod[31:0];
	wire sw_level_mode = (sw_dur_s == 32'h0000_0000);
	wire sw_rise = switch_in & ~sw_prev;

	// Clamped write values
	reg [31:0] next_sw_dur;
	reg [31:0] next_pul_dur;
	reg [31:0] next_cal_dur;
	reg [39:0] next_kt;

	always @* begin
		next_sw_dur = reg_wdata;
		if (reg_wdata > `EPO_SW_DUR_MAX) begin
			next_sw_dur = `EPO_SW_DUR_MAX;
		end
		next_pul_dur = reg_wdata;
		if (reg_wdata < `EPO_PUL_DUR_MIN) begin
			next_pul_dur = `EPO_PUL_DUR_MIN;
		end else if (reg_wdata > `EPO_PUL_DUR_MAX) begin
			next_pul_dur = `EPO_PUL_DUR_MAX;
		end
		next_cal_dur = reg_wdata;
		if (reg_wdata < `EPO_CAL_DUR_MIN) begin
			next_cal_dur = `EPO_CAL_DUR_MIN;
		end else if (reg_wdata > `EPO_CAL_DUR_MAX) begin
			next_cal_dur = `EPO_CAL_DUR_MAX;
		end
		next_kt = kt;
		if (reg_wr && reg_addr == `EPO_ADDR_KT_LO) begin
			next_kt = {kt[39:32], reg_wdata};
		end else if (reg_wr && reg_addr == `EPO_ADDR_KT_HI) begin
			next_kt = {reg_wdata[7:0], kt[31:0]};
		end
		if (next_kt < `EPO_KT_MIN) begin
			next_kt = `EPO_KT_MIN;
		end else if (next_kt > `EPO_KT_MAX) begin
			next_kt = `EPO_KT_MAX;
		end
	end

	// Register writes
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= `EPO_RST_CTRL;
			ports <= `EPO_RST_PORTS;
			sw_dur_s <= `EPO_RST_SW_DUR;
			pul_dur_ms <= `EPO_RST_PUL_DUR;
			cal_dur_ms <= `EPO_RST_CAL_DUR;
			kt <= `EPO_RST_KT;
		end else begin
			kt <= next_kt;
			if (reg_wr) begin
				if (reg_addr == `EPO_ADDR_CTRL) begin
					ctrl <= reg_wdata[4:0];
				end else if (reg_addr == `EPO_ADDR_PORTS) begin
					ports <= reg_wdata[11:0];
				end else if (reg_addr == `EPO_ADDR_SW_DUR) begin
					sw_dur_s <= next_sw_dur;
				end else if (reg_addr == `EPO_ADDR_PUL_DUR) begin
					pul_dur_ms <= next_pul_dur;
				end else if (reg_addr == `EPO_ADDR_CAL_DUR) begin
					cal_dur_ms <= next_cal_dur;
				end
			end
		end
	end

	// Read port: data stand only in the cycle after the strobe
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (!reg_rd) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_addr == `EPO_ADDR_CTRL) begin
			reg_rdata <= {27'h000_0000, ctrl};
		end else if (reg_addr == `EPO_ADDR_PORTS) begin
			reg_rdata <= {20'h0_0000, ports};
		end else if (reg_addr == `EPO_ADDR_SW_DUR) begin
			reg_rdata <= sw_dur_s;
		end else if (reg_addr == `EPO_ADDR_PUL_DUR) begin
			reg_rdata <= pul_dur_ms;
		end else if (reg_addr == `EPO_ADDR_CAL_DUR) begin
			reg_rdata <= cal_dur_ms;
		end else if (reg_addr == `EPO_ADDR_KT_LO) begin
			reg_rdata <= kt[31:0];
		end else if (reg_addr == `EPO_ADDR_KT_HI) begin
			reg_rdata <= {24'h00_0000, kt[39:32]};
		end else if (reg_addr == `EPO_ADDR_STATUS) begin
			reg_rdata <= {16'h0000, fit_sync, chan_q};
		end else if (reg_addr == `EPO_ADDR_LOG_CNT) begin
			reg_rdata <= log_count;
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// Strap is sampled through two flops and then held as a level
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			fit_meta <= 1'b0;
			fit_sync <= 1'b0;
		end else begin
			fit_meta <= option_fitted;
			fit_sync <= fit_meta;
		end
	end

	// One-cycle millisecond enable
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= 32'h0000_0000;
			tick_ms <= 1'b0;
		end else if (div_cnt == TICK_CYCLES - 1) begin
			div_cnt <= 32'h0000_0000;
			tick_ms <= 1'b1;
		end else begin
			div_cnt <= div_cnt + 32'h0000_0001;
			tick_ms <= 1'b0;
		end
	end

	// Switch edge history and change logging
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sw_prev <= 1'b0;
			sw_out_prev <= 1'b0;
			log_event <= 1'b0;
			log_count <= 32'h0000_0000;
		end else begin
			sw_prev <= switch_in;
			sw_out_prev <= sw_out;
			log_event <= 1'b0;
			if (log_en && (sw_out != sw_out_prev)) begin
				log_event <= 1'b1;
				if (log_count != 32'hffff_ffff) begin
					// Count saturates so software never sees a wrap to zero
					log_count <= log_count + 32'h0000_0001;
				end
			end
		end
	end

	// Switch function: level follower, or one pulse per rising input
	epo_pulse_gen u_switch (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.tick_ms(tick_ms),
		.level_mode(sw_level_mode),
		.level_in(switch_in),
		.kyz(1'b0),
		.dur_ms(sw_dur_ms),
		.trig(sw_rise),
		.pulse_out(sw_out)
	);

	// Pulser function
	epo_pulse_gen u_pulser (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.tick_ms(tick_ms),
		.level_mode(1'b0),
		.level_in(1'b0),
		.kyz(pul_kyz),
		.dur_ms(pul_dur_ms),
		.trig(pulser_evt),
		.pulse_out(pul_out)
	);

	// Calibration pulser: integrator then shaper
	epo_energy_integ u_integ (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.int_mode(cal_mode),
		.energy_per_pulse_constant(kt),
		.power_sample(power_sample),
		.power_valid(power_valid),
		.energy_evt(cal_evt)
	);

	epo_pulse_gen u_cal (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.tick_ms(tick_ms),
		.level_mode(1'b0),
		.level_in(1'b0),
		.kyz(cal_kyz),
		.dur_ms(cal_dur_ms),
		.trig(cal_evt),
		.pulse_out(cal_out)
	);

	// Channel routing: code i+1 selects channel i; code zero drives nothing
	genvar i;
	generate
		for (i = 0; i < `EPO_NUM_CHAN; i = i + 1) begin : g_chan
			localparam integer CODE_NUM = i + 1;
			localparam [3:0] CODE = CODE_NUM[3:0];
			// Channels 2 to 6 are the onboard relays and solid-state output
			localparam ONBOARD = (i >= 2) && (i <= 6);
			wire hit = ((sw_port == CODE) & sw_out) |
				((pul_port == CODE) & pul_out) |
				((cal_port == CODE) & cal_out);
			assign next_chan[i] = ONBOARD ? (hit & fit_sync) : hit;
		end
	endgenerate

	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			chan_q <= {`EPO_NUM_CHAN{1'b0}};
		end else begin
			chan_q <= next_chan;
		end
	end

	assign active_energy_indicator = chan_q[0];
	assign reactive_energy_indicator = chan_q[1];
	assign relay_out = chan_q[5:2];
	assign solid_state_out = chan_q[6];
	assign expander_out = chan_q[14:7];
endmodule

/* File: testbench/epo_outputs_asserts.sv */
// Checker for the energy pulse output stage, watching top-level ports only.
// Assumes configuration changes only through register writes on the plain port.
`timescale 1ns/100ps
module epo_outputs_asserts (
	// Clock and reset
	input wire core_clk,
	input wire rst_n,
	// Register port
	input wire [3:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	// Function inputs
	input wire switch_in,
	input wire pulser_evt,
	input wire option_fitted,
	// Channel outputs
	input wire active_energy_indicator,
	input wire [3:0] relay_out,
	input wire solid_state_out,
	input wire [7:0] expander_out,
	input wire log_event
);
	reg [4:0] ctrl;
	reg [11:0] ports;
	reg sw_lvl;
	// Shadow of the settings that the properties depend on
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= 5'h00;
			ports <= 12'h000;
			sw_lvl <= 1'b1;
		end else if (reg_wr) begin
			if (reg_addr == 4'h0)
				ctrl <= reg_wdata[4:0];
			if (reg_addr == 4'h1)
				ports <= reg_wdata[11:0];
			if (reg_addr == 4'h2)
				sw_lvl <= (reg_wdata == 32'h0000_0000);
		end
	end
	wire sw_cfg = ports[3:0] == 4'h3 && ports[7:4] != 4'h3 && ports[11:8] != 4'h3 && sw_lvl;
	wire pul_cfg = ports[7:4] == 4'h1 && ports[3:0] != 4'h1 && ports[11:8] != 4'h1;
	wire exp_free = ports[3:0] < 4'h8 && ports[7:4] < 4'h8 && ports[11:8] < 4'h8;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	property p_rd_idle;
		!$past(reg_rd) |-> reg_rdata == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside read cycle");
	property p_unmapped;
		reg_rd && reg_addr > 4'h8 |=> reg_rdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_strap_off;
		(!option_fitted) [*5] |-> relay_out == 4'h0 && !solid_state_out;
	endproperty
	a_strap_off: assert property (p_strap_off) else $error("onboard output without option");
	property p_sw_level;
		option_fitted [*6] ##0 sw_cfg |-> ##2 (!sw_cfg || relay_out[0] == $past(switch_in, 2));
	endproperty
	a_sw_level: assert property (p_sw_level) else $error("relay does not follow switch");
	property p_log_gate;
		log_event |-> ctrl[0] || $past(ctrl[0]);
	endproperty
	a_log_gate: assert property (p_log_gate) else $error("log strobe with logging off");
	property p_pul_pulse;
		pulser_evt && pul_cfg && !ctrl[1] |-> ##2 active_energy_indicator;
	endproperty
	a_pul_pulse: assert property (p_pul_pulse) else $error("pulser pulse missing");
	property p_pul_kyz;
		pulser_evt && !$past(pulser_evt) && pul_cfg && ctrl[1]
			|-> ##2 active_energy_indicator != $past(active_energy_indicator);
	endproperty
	a_pul_kyz: assert property (p_pul_kyz) else $error("transition missing");
	property p_exp_free;
		exp_free [*4] |-> expander_out == 8'h00;
	endproperty
	a_exp_free: assert property (p_exp_free) else $error("unrouted expander output");
	c_log: cover property (log_event);
	c_kyz: cover property (pulser_evt && ctrl[1]);
	c_strap: cover property (option_fitted ##1 !option_fitted);
endmodule
bind epo_outputs epo_outputs_asserts u_chk (.core_clk(core_clk), .rst_n(rst_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .switch_in(switch_in), .pulser_evt(pulser_evt),
	.option_fitted(option_fitted), .active_energy_indicator(active_energy_indicator),
	.relay_out(relay_out), .solid_state_out(solid_state_out), .expander_out(expander_out),
	.log_event(log_event));

/* File: testbench/epo_pulse_counter.sv */
// Far-side pulse counter: counts energised edges and times the last pulse on one channel.
// Assumes the channel is a registered level on core_clk.
`timescale 1ns/100ps
module epo_pulse_counter (
	// Clock and reset
	input wire core_clk,
	input wire rst_n,
	// Watched channel
	input wire chan,
	// Results
	output reg [31:0] rises,
	output reg [31:0] last_len
);
	reg prev;
	reg [31:0] run;
	always @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			prev <= 1'b0;
			rises <= 32'h0;
			run <= 32'h0;
			last_len <= 32'h0;
		end else begin
			prev <= chan;
			if (chan && !prev)
				rises <= rises + 32'h1;
			run <= chan ? run + 32'h1 : 32'h0;
			if (!chan && prev)
				last_len <= run;
		end
	end
endmodule

/* File: testbench/energy_pulse_outputs_tb_top.sv */
// Bench for the energy pulse output stage: registers, switch, pulser, calibration pulser.
// Assumes a short tick so each millisecond lasts TK clock cycles.
`timescale 1ns/100ps
module energy_pulse_outputs_tb_top;
	localparam TK = 4;
	reg core_clk = 1'b0;
	reg rst_n = 1'b0;
	reg [3:0] reg_addr = 4'h0;
	reg [31:0] reg_wdata = 32'h0;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	reg switch_in = 1'b0;
	reg pulser_evt = 1'b0;
	reg [31:0] power_sample = 32'h0;
	reg power_valid = 1'b0;
	reg option_fitted = 1'b0;
	wire [31:0] reg_rdata;
	wire act;
	wire rea;
	wire [3:0] relay_out;
	wire ss_out;
	wire [7:0] exp_out;
	wire log_event;
	wire [31:0] act_rises;
	wire [31:0] act_len;
	wire [31:0] rea_rises;
	wire [14:0] chans = {exp_out, ss_out, relay_out, rea, act};
	integer num_errors = 0;
	integer checks_done = 0;
	integer log_pulses = 0;
	integer seed = 32'ha01c4c26;
	integer cycles = 0;
	integer i;
	integer m;
	integer s;
	integer acc;
	integer cnt;
	integer base;
	reg [31:0] v;
	epo_outputs #(.TICK_CYCLES(TK)) DUT (.core_clk(core_clk), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .switch_in(switch_in), .pulser_evt(pulser_evt),
		.power_sample(power_sample), .power_valid(power_valid), .option_fitted(option_fitted),
		.active_energy_indicator(act), .reactive_energy_indicator(rea), .relay_out(relay_out),
		.solid_state_out(ss_out), .expander_out(exp_out), .log_event(log_event));
	epo_pulse_counter u_act (.core_clk(core_clk), .rst_n(rst_n), .chan(act),
		.rises(act_rises), .last_len(act_len));
	epo_pulse_counter u_rea (.core_clk(core_clk), .rst_n(rst_n), .chan(rea),
		.rises(rea_rises), .last_len());
	always #2.5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles = cycles + 1;
		if (log_event === 1'b1)
			log_pulses = log_pulses + 1;
		if (cycles == 10000) begin
			num_errors = num_errors + 1;
			wrap_up;
		end
	end
	task wrap_up;
		begin
			if (num_errors == 0 && checks_done > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			checks_done = checks_done + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("BAD %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	// Channel levels and counted pulses share the core comparison
	task chk_lvl(input [31:0] got, input [31:0] exp);
		chk(got, exp);
	endtask
	task chk_cnt(input [31:0] got, input [31:0] exp);
		chk(got, exp);
	endtask
	task idle(input integer n);
		begin
			repeat (n) @(posedge core_clk);
			@(negedge core_clk);
		end
	endtask
	task wr(input [3:0] a, input [31:0] d);
		begin
			@(posedge core_clk);
			reg_wr <= 1'b1;
			reg_addr <= a;
			reg_wdata <= d;
			@(posedge core_clk);
			reg_wr <= 1'b0;
		end
	endtask
	task rd(input [3:0] a, input [31:0] exp);
		begin
			@(posedge core_clk);
			reg_rd <= 1'b1;
			reg_addr <= a;
			@(posedge core_clk);
			reg_rd <= 1'b0;
			@(negedge core_clk);
			chk(reg_rdata, exp);
		end
	endtask
	// One strobe of a pulser event (kind 0) or a power sample, then a quiet gap
	task evt(input integer kind, input [31:0] smp);
		begin
			@(posedge core_clk);
			pulser_evt <= (kind == 0);
			power_valid <= (kind != 0);
			power_sample <= smp;
			@(posedge core_clk);
			pulser_evt <= 1'b0;
			power_valid <= 1'b0;
			idle(120);
		end
	endtask
	function [31:0] clamp(input [31:0] x, input [31:0] lo, input [31:0] hi);
		clamp = x < lo ? lo : (x > hi ? hi : x);
	endfunction
	initial begin
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(4'h3, 32'h14);
		rd(4'h4, 32'ha);
		rd(4'h5, 32'h64);
		rd(4'hc, 32'h0);
		for (i = 0; i < 6; i = i + 1) begin
			m = 2 + i % 3;
			v = $random(seed);
			if (i >= 3)
				v = v % 32'd30;
			wr(m[3:0], v);
			rd(m[3:0], clamp(v, m == 2 ? 0 : (m == 3 ? 20 : 10),
				m == 2 ? 2000000 : (m == 3 ? 2000000000 : 1000)));
		end
		wr(4'h7, 32'hffff);
		rd(4'h7, 32'h0);
		wr(4'h2, 32'h0);
		wr(4'h3, 32'h14);
		wr(4'h4, 32'ha);
		option_fitted <= 1'b1;
		wr(4'h0, 32'h1);
		wr(4'h1, 32'h3);
		cnt = 0;
		for (i = 0; i < 20; i = i + 1) begin
			@(posedge core_clk);
			v = $random(seed);
			if (v[0] != switch_in)
				cnt = cnt + 1;
			switch_in <= v[0];
		end
		idle(4);
		chk_lvl({31'h0, relay_out[0]}, {31'h0, switch_in});
		rd(4'h8, cnt);
		chk_cnt(log_pulses, cnt);
		@(posedge core_clk);
		option_fitted <= 1'b0;
		idle(8);
		@(posedge core_clk);
		switch_in <= ~switch_in;
		idle(4);
		chk_lvl({27'h0, ss_out, relay_out}, 32'h0);
		@(posedge core_clk);
		option_fitted <= 1'b1;
		wr(4'h1, 32'h13);
		base = act_rises;
		for (i = 0; i < 3; i = i + 1)
			evt(0, 0);
		chk_cnt(act_rises - base, 32'h3);
		chk_cnt({31'h0, act_len >= 19 * TK + 1 && act_len <= 20 * TK}, 32'h1);
		wr(4'h0, 32'h2);
		base = act_rises;
		for (i = 0; i < 4; i = i + 1)
			evt(0, 0);
		chk_cnt(act_rises - base, 32'h2);
		wr(4'h1, 32'h0);
		evt(0, 0);
		for (i = 0; i < 16; i = i + 1) begin
			wr(4'h1, i << 4);
			idle(3);
			chk_lvl({17'h0, chans}, i == 0 ? 32'h0 : 32'h1 << (i - 1));
		end
		wr(4'h1, 32'h200);
		for (m = 0; m < 4; m = m + 1) begin
			wr(4'h0, m << 3);
			base = rea_rises;
			acc = 0;
			cnt = 0;
			for (i = 0; i < 3; i = i + 1) begin
				s = (i == 1) ? -100 : 100;
				if (m == 3)
					acc = acc + s;
				else if (m == 2 || (m == 0) == (s > 0))
					acc = acc + (s < 0 ? -s : s);
				if (acc >= 100) begin
					cnt = cnt + 1;
					acc = acc - 100;
				end
				evt(1, s);
			end
			chk_cnt(rea_rises - base, cnt);
		end
		wrap_up;
	end
endmodule
